/* File: verilog/spi_pin_defines.svh */
// Offsets, field positions, reset values and timing counts for the pin mode and baud block
`ifndef SPI_PIN_DEFINES_SVH
`define SPI_PIN_DEFINES_SVH
`define OFF_CONTROL_ONE 4'h0
`define OFF_CONTROL_TWO 4'h1
`define OFF_BAUD_RATE 4'h2
`define OFF_STATUS 4'h3
`define OFF_SIDEBAND 4'h8
`define ADDR_CONTROL_ONE 6'h00
`define ADDR_CONTROL_TWO 6'h04
`define ADDR_BAUD_RATE 6'h08
`define ADDR_STATUS 6'h0C
`define ADDR_SIDEBAND 6'h20
`define C1_MASTER_SLAVE_SELECT_BIT 4
`define C1_SELECT_OUTPUT_ENABLE_BIT 1
`define C2_MODE_FAULT_DETECT_ENABLE_BIT 4
`define C2_BIDIR_OUTPUT_ENABLE_BIT 3
`define C2_SWAI_BIT 1
`define C2_PINSEL_BIT 0
`define C2_WRITE_MASK 8'h1B
`define BR_WRITE_MASK 8'h77
`define ST_MODE_FAULT_FLAG_BIT 4
`define CONTROL_ONE_RESET 8'h04
`define CONTROL_TWO_RESET 8'h00
`define BAUD_RATE_RESET 8'h00
`define CLK_PERIOD_NS 8
`define SYNC_STAGES 2
`define DIV_COUNT_W 12
`endif

/* File: verilog/spi_pin_pkg.sv */
// Types shared by the pin mode and baud block
package spi_pin_pkg;
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_RUN = 2'b01,
        LINK_WAIT = 2'b10
    } link_state_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_t;
endpackage

/* File: verilog/pin_sync.sv */
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module pin_sync (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic pin_in,
    output logic sync_out
);
    logic first_r;
    logic sync_r;
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            first_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            first_r <= pin_in;
            sync_r <= first_r;
        end
    end
    assign sync_out = sync_r;
endmodule // pin_sync

/* File: verilog/baud_divider.sv */
// Baud divider: one-cycle edge enable every divisor/2 bus cycles
`timescale 1ns/1ps
`include "spi_pin_defines.svh"
module baud_divider (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] baud_preselect_in,
    input wire logic [2:0] baud_select_in,
    input wire logic run_in,
    input wire logic hold_in,
    output logic edge_out
);
    logic [`DIV_COUNT_W-1:0] cnt_r;
    logic [`DIV_COUNT_W-1:0] cnt_nxt;
    logic edge_r;
    logic edge_nxt;
    logic [`DIV_COUNT_W-1:0] half;
    // Half divisor: (pre+1) * 2^sel, so a full clock is (pre+1) * 2^(sel+1)
    function automatic logic [`DIV_COUNT_W-1:0] half_div(input logic [2:0] pre, input logic [2:0] sel);
        half_div = `DIV_COUNT_W'({1'b0, pre} + 4'h1) << sel;
    endfunction
    always_comb begin
        half = half_div(baud_preselect_in, baud_select_in);
        cnt_nxt = cnt_r;
        edge_nxt = 1'b0;
        if (!run_in) begin
            cnt_nxt = '0;
        end else if (hold_in) begin
            cnt_nxt = cnt_r;
        end else if (cnt_r == half - `DIV_COUNT_W'(1)) begin
            cnt_nxt = '0;
            edge_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + `DIV_COUNT_W'(1);
        end
    end
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_r <= '0;
            edge_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            edge_r <= edge_nxt;
        end
    end
    assign edge_out = edge_r;
endmodule // baud_divider

/* File: verilog/spi_pin_mode_and_baud.sv */
// Pin mode control, baud rate generation and master abort logic of the serial interface
`timescale 1ns/1ps
`include "spi_pin_defines.svh"
module spi_pin_mode_and_baud
    import spi_pin_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    input wire logic wait_mode_in,
    input wire logic ss_pin_in,
    input wire logic mosi_pin_in,
    input wire logic miso_pin_in,
    input wire logic sck_pin_in,
    output logic ss_pin_out,
    output logic ss_pin_oe_out,
    output logic mosi_pin_out,
    output logic mosi_pin_oe_out,
    output logic miso_pin_out,
    output logic miso_pin_oe_out,
    output logic sck_pin_out,
    output logic sck_pin_oe_out,
    output logic idle_request_out,
    output logic serial_data_in_out,
    output logic serial_clock_in_out
);
    // ----------------------------------------
    // Registers and bus
    // ----------------------------------------
    logic [7:0] ctrl_one_r, ctrl_one_nxt;
    logic [7:0] ctrl_two_r, ctrl_two_nxt;
    logic [7:0] baud_r, baud_nxt;
    logic [7:0] side_r, side_nxt;
    logic mode_fault_flag_r, mode_fault_flag_nxt;
    logic fault_armed_r, fault_armed_nxt;
    bus_state_t bus_r, bus_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] resp_r, resp_nxt;
    logic wr_hit, rd_hit, wait_r;
    logic [7:0] wbyte;
    logic master_slave_select, select_output_enable;
    logic mode_fault_detect_enable, bidir_output_enable, stop_in_wait, bidir_pin_select;
    logic [2:0] baud_preselect, baud_select;
    logic abort;
    logic ss_sync, mosi_sync, miso_sync, sck_sync, wait_sync;

    assign master_slave_select = ctrl_one_r[`C1_MASTER_SLAVE_SELECT_BIT];
    assign select_output_enable = ctrl_one_r[`C1_SELECT_OUTPUT_ENABLE_BIT];
    assign mode_fault_detect_enable = ctrl_two_r[`C2_MODE_FAULT_DETECT_ENABLE_BIT];
    assign bidir_output_enable = ctrl_two_r[`C2_BIDIR_OUTPUT_ENABLE_BIT];
    assign stop_in_wait = ctrl_two_r[`C2_SWAI_BIT];
    assign bidir_pin_select = ctrl_two_r[`C2_PINSEL_BIT];
    assign baud_preselect = baud_r[6:4];
    assign baud_select = baud_r[2:0];
    assign wbyte = avs_writedata_in[7:0];

    // Bus request taken in idle; answer registered one cycle later
    assign wr_hit = (bus_r == BUS_IDLE) && avs_write_in && avs_byteenable_in[0];
    assign rd_hit = (bus_r == BUS_IDLE) && avs_read_in;

    always_comb begin
        ctrl_one_nxt = ctrl_one_r;
        ctrl_two_nxt = ctrl_two_r;
        baud_nxt = baud_r;
        side_nxt = side_r;
        rdata_nxt = rdata_r;
        resp_nxt = 2'b00;
        bus_nxt = BUS_IDLE;
        fault_armed_nxt = fault_armed_r;
        abort = 1'b0;
        if (bus_r == BUS_IDLE && (avs_read_in || avs_write_in)) begin
            bus_nxt = BUS_RESP;
        end
        if (wr_hit) begin
            if (avs_address_in == `ADDR_CONTROL_ONE) begin
                ctrl_one_nxt = wbyte;
                if (ctrl_one_r[`C1_MASTER_SLAVE_SELECT_BIT] != wbyte[`C1_MASTER_SLAVE_SELECT_BIT]) begin
                    abort = 1'b1;
                end else if (master_slave_select && (ctrl_one_r[3:0] != wbyte[3:0])) begin
                    abort = 1'b1;
                end
                if (fault_armed_r) begin
                    fault_armed_nxt = 1'b0;
                end
            end else if (avs_address_in == `ADDR_CONTROL_TWO) begin
                ctrl_two_nxt = wbyte & `C2_WRITE_MASK;
                if (master_slave_select) begin
                    if ((wbyte[`C2_MODE_FAULT_DETECT_ENABLE_BIT] != mode_fault_detect_enable) ||
                        (wbyte[`C2_PINSEL_BIT] != bidir_pin_select)) begin
                        abort = 1'b1;
                    end
                    if (bidir_pin_select && (wbyte[`C2_BIDIR_OUTPUT_ENABLE_BIT] != bidir_output_enable)) begin
                        abort = 1'b1;
                    end
                end
            end else if (avs_address_in == `ADDR_BAUD_RATE) begin
                baud_nxt = wbyte & `BR_WRITE_MASK;
                if (master_slave_select && ((wbyte & `BR_WRITE_MASK) != baud_r)) begin
                    abort = 1'b1;
                end
            end else if (avs_address_in == `ADDR_SIDEBAND) begin
                side_nxt = {7'h00, wbyte[0]};
            end else if (avs_address_in != `ADDR_STATUS) begin
                resp_nxt = 2'b10;
            end
        end else if (bus_r == BUS_IDLE && avs_write_in) begin
            if (avs_address_in > `ADDR_SIDEBAND) begin
                resp_nxt = 2'b10;
            end
        end
        if (rd_hit) begin
            rdata_nxt = 32'h0000_0000;
            if (avs_address_in == `ADDR_CONTROL_ONE) begin
                rdata_nxt = {24'h000000, ctrl_one_r};
            end else if (avs_address_in == `ADDR_CONTROL_TWO) begin
                rdata_nxt = {24'h000000, ctrl_two_r};
            end else if (avs_address_in == `ADDR_BAUD_RATE) begin
                rdata_nxt = {24'h000000, baud_r};
            end else if (avs_address_in == `ADDR_STATUS) begin
                rdata_nxt = {27'h0000000, mode_fault_flag_r, 4'h0};
                if (mode_fault_flag_r) begin
                    fault_armed_nxt = 1'b1;
                end
            end else if (avs_address_in == `ADDR_SIDEBAND) begin
                rdata_nxt = {24'h000000, side_r};
            end else begin
                resp_nxt = 2'b10;
            end
        end
    end

    // ----------------------------------------
    // Mode fault flag
    // ----------------------------------------
    logic fault_event;
    logic fault_clear;
    assign fault_event = master_slave_select && mode_fault_detect_enable && !select_output_enable && !ss_sync;
    assign fault_clear = wr_hit && (avs_address_in == `ADDR_CONTROL_ONE) && fault_armed_r;
    always_comb begin
        mode_fault_flag_nxt = mode_fault_flag_r;
        if (fault_event) begin
            mode_fault_flag_nxt = 1'b1;
        end else if (fault_clear) begin
            mode_fault_flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_one_r <= `CONTROL_ONE_RESET;
            ctrl_two_r <= `CONTROL_TWO_RESET;
            baud_r <= `BAUD_RATE_RESET;
            side_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'b00;
            bus_r <= BUS_IDLE;
            wait_r <= 1'b1;
            fault_armed_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
        end else begin
            ctrl_one_r <= ctrl_one_nxt;
            ctrl_two_r <= ctrl_two_nxt;
            baud_r <= baud_nxt;
            side_r <= side_nxt;
            rdata_r <= rdata_nxt;
            resp_r <= resp_nxt;
            bus_r <= bus_nxt;
            wait_r <= (bus_nxt == BUS_IDLE);
            fault_armed_r <= fault_armed_nxt;
            mode_fault_flag_r <= mode_fault_flag_nxt;
        end
    end
    assign avs_readdata_out = rdata_r;
    assign avs_response_out = resp_r;
    assign avs_waitrequest_out = wait_r;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pin_sync u_ss_sync (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .pin_in(ss_pin_in),
        .sync_out(ss_sync));
    pin_sync u_mosi_sync (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .pin_in(mosi_pin_in),
        .sync_out(mosi_sync));
    pin_sync u_miso_sync (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .pin_in(miso_pin_in),
        .sync_out(miso_sync));
    pin_sync u_sck_sync (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .pin_in(sck_pin_in),
        .sync_out(sck_sync));
    pin_sync u_wait_sync (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .pin_in(wait_mode_in),
        .sync_out(wait_sync));

    // ----------------------------------------
    // Serial clock generation
    // ----------------------------------------
    link_state_t link_r, link_nxt;
    logic sck_r, sck_nxt;
    logic half_edge;
    logic hold;
    assign hold = stop_in_wait && wait_sync;
    baud_divider u_div (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .baud_preselect_in(baud_preselect),
        .baud_select_in(baud_select),
        .run_in(link_r != LINK_IDLE),
        .hold_in(hold),
        .edge_out(half_edge)
    );
    always_comb begin
        link_nxt = link_r;
        sck_nxt = sck_r;
        case (link_r)
            LINK_IDLE: begin
                sck_nxt = ctrl_one_r[3];
                if (master_slave_select && !abort) begin
                    link_nxt = LINK_RUN;
                end
            end
            LINK_RUN: begin
                if (hold) begin
                    link_nxt = LINK_WAIT;
                end else if (half_edge) begin
                    sck_nxt = !sck_r;
                end
            end
            LINK_WAIT: begin
                if (!hold) begin
                    link_nxt = LINK_RUN;
                end
            end
            default: begin
                link_nxt = LINK_IDLE;
            end
        endcase
        if (abort || !master_slave_select) begin
            link_nxt = LINK_IDLE;
            sck_nxt = ctrl_one_nxt[3];
        end
    end

    // ----------------------------------------
    // Pin roles
    // ----------------------------------------
    logic ss_o_nxt, ss_oe_nxt, mosi_oe_nxt, miso_oe_nxt, din_nxt, idle_nxt;
    logic ss_o_r, ss_oe_r, mosi_oe_r, miso_oe_r, din_r, idle_r, sck_oe_r, sclk_in_r;
    always_comb begin
        ss_o_nxt = 1'b1;
        ss_oe_nxt = 1'b0;
        if (master_slave_select && mode_fault_detect_enable && select_output_enable) begin
            ss_o_nxt = (link_r == LINK_IDLE);
            ss_oe_nxt = 1'b1;
        end
        if (master_slave_select) begin
            if (!bidir_pin_select) begin
                mosi_oe_nxt = 1'b1;
                miso_oe_nxt = 1'b0;
                din_nxt = miso_sync;
            end else begin
                mosi_oe_nxt = bidir_output_enable;
                miso_oe_nxt = 1'b0;
                din_nxt = mosi_sync;
            end
        end else begin
            if (!bidir_pin_select) begin
                mosi_oe_nxt = 1'b0;
                miso_oe_nxt = ss_sync == 1'b0;
                din_nxt = mosi_sync;
            end else begin
                mosi_oe_nxt = 1'b0;
                miso_oe_nxt = bidir_output_enable && !ss_sync;
                din_nxt = miso_sync;
            end
        end
        idle_nxt = abort || (link_nxt == LINK_IDLE);
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link_r <= LINK_IDLE;
            sck_r <= 1'b0;
            ss_o_r <= 1'b1;
            ss_oe_r <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_oe_r <= 1'b0;
            din_r <= 1'b0;
            idle_r <= 1'b1;
            sck_oe_r <= 1'b0;
            sclk_in_r <= 1'b0;
        end else begin
            link_r <= link_nxt;
            sck_r <= sck_nxt;
            ss_o_r <= ss_o_nxt;
            ss_oe_r <= ss_oe_nxt;
            mosi_oe_r <= mosi_oe_nxt;
            miso_oe_r <= miso_oe_nxt;
            din_r <= din_nxt;
            idle_r <= idle_nxt;
            sck_oe_r <= master_slave_select;
            sclk_in_r <= sck_sync;
        end
    end
    assign ss_pin_out = ss_o_r;
    assign ss_pin_oe_out = ss_oe_r;
    assign mosi_pin_out = 1'b0;
    assign mosi_pin_oe_out = mosi_oe_r;
    assign miso_pin_out = 1'b0;
    assign miso_pin_oe_out = miso_oe_r;
    assign sck_pin_out = sck_r;
    assign sck_pin_oe_out = sck_oe_r;
    assign idle_request_out = idle_r;
    assign serial_data_in_out = din_r;
    assign serial_clock_in_out = sclk_in_r;
endmodule // spi_pin_mode_and_baud

/* File: bench/spi_far_end.sv */
// Far-side serial peripheral model
`timescale 1ns/1ps
module spi_far_end #(
    parameter int HALF = 4
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic sel_low_in,
    input wire logic drive_in,
    input wire logic data_in,
    input wire logic clock_run_in,
    input wire logic ss_pin_out,
    input wire logic ss_pin_oe_out,
    input wire logic mosi_pin_out,
    input wire logic mosi_pin_oe_out,
    input wire logic miso_pin_out,
    input wire logic miso_pin_oe_out,
    input wire logic sck_pin_out,
    input wire logic sck_pin_oe_out,
    output logic ss_pin_in,
    output logic mosi_pin_in,
    output logic miso_pin_in,
    output logic sck_pin_in
);
    // --------------------------------
    // Clock and released-line pattern
    // --------------------------------
    logic pat_r, pat_nxt, clk_r, clk_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    always_comb begin
        pat_nxt = !pat_r;
        cnt_nxt = 4'h0;
        clk_nxt = 1'b0;
        if (clock_run_in) begin
            cnt_nxt = (cnt_r == 4'(HALF - 1)) ? 4'h0 : cnt_r + 4'h1;
            clk_nxt = (cnt_r == 4'(HALF - 1)) ? !clk_r : clk_r;
        end
    end
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pat_r <= 1'b0;
            cnt_r <= 4'h0;
            clk_r <= 1'b0;
        end else begin
            pat_r <= pat_nxt;
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
        end
    end
    // Select is high unless sel_low_in; released mosi carries data_in and miso its inverse, or a toggle pattern, sck the model clock
    assign ss_pin_in = ss_pin_oe_out ? ss_pin_out : !sel_low_in;
    assign mosi_pin_in = mosi_pin_oe_out ? mosi_pin_out : (drive_in ? data_in : pat_r);
    assign miso_pin_in = miso_pin_oe_out ? miso_pin_out : (drive_in ? !data_in : pat_r);
    assign sck_pin_in = sck_pin_oe_out ? sck_pin_out : clk_r;
endmodule // spi_far_end

/* File: bench/spi_pin_mode_and_baud_checker.sv */
// Assertion checker for the pin mode and baud block
`timescale 1ns/1ps
module spi_pin_mode_and_baud_checker (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [1:0] avs_response_out,
    input wire logic wait_mode_in,
    input wire logic ss_pin_in,
    input wire logic ss_pin_oe_out,
    input wire logic mosi_pin_oe_out,
    input wire logic miso_pin_oe_out,
    input wire logic sck_pin_out,
    input wire logic idle_request_out
);
    // --------------------------------
    // Register shadows
    // --------------------------------
    logic [7:0] c1_r, c1_nxt, c2_r, c2_nxt, br_r, br_nxt;
    logic take;
    logic [4:0] mode;
    always_comb begin
        take = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
        c1_nxt = (take && avs_address_in == 6'h00) ? avs_writedata_in[7:0] : c1_r;
        c2_nxt = (take && avs_address_in == 6'h04) ? avs_writedata_in[7:0] & 8'h1B : c2_r;
        br_nxt = (take && avs_address_in == 6'h08) ? avs_writedata_in[7:0] & 8'h77 : br_r;
        mode = {c1_r[4], c1_r[1], c2_r[4], c2_r[3], c2_r[0]};
    end
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            c1_r <= 8'h04;
            c2_r <= 8'h00;
            br_r <= 8'h00;
        end else begin
            c1_r <= c1_nxt;
            c2_r <= c2_nxt;
            br_r <= br_nxt;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_ss_slave_input: assert property (($stable(mode) && !mode[4]) [*2] |-> !ss_pin_oe_out)
        else $error("select driven in slave mode");
    a_ss_unused: assert property (($stable(mode) && mode[4] && !mode[2]) [*2] |-> !ss_pin_oe_out)
        else $error("select driven with fault enable low");
    a_ss_drive: assert property (($stable(mode) && mode[4] && mode[3] && mode[2]) [*2] |-> ss_pin_oe_out)
        else $error("select output not driven");
    a_normal_roles: assert property (($stable(mode) && $stable(ss_pin_in) && !mode[0]) [*3] |->
        mosi_pin_oe_out == mode[4] && miso_pin_oe_out == (!mode[4] && !ss_pin_in))
        else $error("normal pin roles wrong");
    a_bidir_gate: assert property (($stable(mode) && $stable(ss_pin_in) && mode[0]) [*3] |->
        mosi_pin_oe_out == (mode[4] && mode[1]) && miso_pin_oe_out == (!mode[4] && mode[1] && !ss_pin_in))
        else $error("bidirectional buffer gating wrong");
    a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer late");
    a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer held too long");
    a_unmapped_err: assert property (avs_read_in && avs_waitrequest_out && avs_address_in == 6'h10 |=>
        avs_response_out == 2'h2 && avs_readdata_out == 32'h0) else $error("unmapped read not refused");
    a_reserved_zero: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_baud_abort: assert property (take && avs_address_in == 6'h08 && c1_r[4] &&
        (avs_writedata_in[7:0] & 8'h77) != br_r |-> ##[0:3] idle_request_out) else $error("baud change no abort");
    a_pin_abort: assert property (take && avs_address_in == 6'h04 && c1_r[4] &&
        (avs_writedata_in[4] != c2_r[4] || avs_writedata_in[0] != c2_r[0]) |-> ##[0:3] idle_request_out)
        else $error("control change no abort");
    a_wait_freeze: assert property ((c1_r[4] && c2_r[1] && wait_mode_in) [*6] |-> $stable(sck_pin_out))
        else $error("serial clock runs in wait");
    c_baud_write: cover property (take && avs_address_in == 6'h08);
    c_wait_stop: cover property ((c1_r[4] && c2_r[1] && wait_mode_in) [*6]);
    c_unmapped: cover property (avs_read_in && !avs_waitrequest_out && avs_response_out == 2'h2);
endmodule // spi_pin_mode_and_baud_checker
bind spi_pin_mode_and_baud spi_pin_mode_and_baud_checker u_checker (.*);

/* File: bench/spi_pin_mode_and_baud_bench.sv */
// Self-checking testbench for the pin mode and baud block
`timescale 1ns/1ps
module spi_pin_mode_and_baud_bench;
    logic core_clk_in = 1'b0;
    logic sys_rst_in, avs_read_in, avs_write_in, wait_mode_in, avs_waitrequest_out;
    logic sel_low_in, drive_in, data_in, clock_run_in, ss_pin_in, mosi_pin_in, miso_pin_in, sck_pin_in;
    logic ss_pin_out, ss_pin_oe_out, mosi_pin_out, mosi_pin_oe_out, miso_pin_out, miso_pin_oe_out;
    logic sck_pin_out, sck_pin_oe_out, idle_request_out, serial_data_in_out, serial_clock_in_out;
    logic [5:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic [3:0] avs_byteenable_in;
    logic [1:0] avs_response_out, resp_q;
    int failures = 0;
    int checks = 0;
    spi_pin_mode_and_baud dut (.*);
    spi_far_end far (.*);
    always #4 core_clk_in = !core_clk_in;
    // --------------------------------
    // Shared tasks
    // --------------------------------
    task give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= w;
        avs_read_in <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        q = avs_readdata_out;
        resp_q = avs_response_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n == 20) begin
            failures++;
            give_verdict();
        end
    endtask
    task rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task wr_abort(input logic [5:0] a, input logic [7:0] d);
        logic seen;
        bus(1'b1, a, d);
        seen = idle_request_out;
        repeat (4) begin
            tick(1);
            seen = seen | idle_request_out;
        end
        chk(seen, 32'h1);
    endtask
    task moves_of(input logic use_pin, output int moves);
        logic last, now;
        moves = 0;
        last = use_pin ? sck_pin_out : serial_clock_in_out;
        repeat (40) begin
            tick(1);
            now = use_pin ? sck_pin_out : serial_clock_in_out;
            if (now !== last) moves++;
            last = now;
        end
    endtask
    task sck_period(output int p);
        int n, k;
        logic prev;
        k = 0;
        p = 0;
        prev = sck_pin_out;
        for (n = 0; n < 600 && k < 2; n++) begin
            tick(1);
            if (k == 1) p++;
            if (sck_pin_out === 1'b1 && prev === 1'b0) k++;
            prev = sck_pin_out;
        end
        if (k < 2) begin
            failures++;
            give_verdict();
        end
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task t_regs;
        rd_chk(6'h00, 32'h04);
        rd_chk(6'h04, 32'h00);
        rd_chk(6'h08, 32'h00);
        bus(1'b1, 6'h04, 8'hFF);
        bus(1'b1, 6'h08, 8'hFF);
        rd_chk(6'h04, 32'h1B);
        rd_chk(6'h08, 32'h77);
        bus(1'b1, 6'h10, 8'hFF);
        rd_chk(6'h10, 32'h00);
        chk({30'h0, resp_q}, 32'h2);
        bus(1'b1, 6'h20, 8'hFF);
        rd_chk(6'h20, 32'h01);
        bus(1'b1, 6'h04, 8'h00);
        bus(1'b1, 6'h08, 8'h00);
    endtask
    task t_roles;
        logic m, s, f, oe, p, eso;
        sel_low_in <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            {m, s, f, oe, p} = 5'(i);
            eso = !m & (!p | oe);
            bus(1'b1, 6'h00, {3'h0, m, 2'h0, s, 1'h0});
            bus(1'b1, 6'h04, {3'h0, f, oe, 2'h0, p});
            tick(8);
            chk(ss_pin_oe_out, m & f & s);
            chk(ss_pin_out, !(m & f & s));
            chk(mosi_pin_oe_out, m & (!p | oe));
            chk(miso_pin_oe_out, eso);
            chk(serial_data_in_out, (m ^ p) & !eso);
        end
        rd_chk(6'h0C, 32'h10);
        sel_low_in <= 1'b0;
    endtask
    task t_baud;
        logic [7:0] tab [6];
        int p;
        tab = '{8'h10, 8'h02, 8'h21, 8'h53, 8'h70, 8'h00};
        bus(1'b1, 6'h04, 8'h00);
        bus(1'b1, 6'h00, 8'h10);
        for (int i = 0; i < 6; i++) begin
            wr_abort(6'h08, tab[i]);
            sck_period(p);
            chk(p, (int'(tab[i][6:4]) + 1) << (int'(tab[i][2:0]) + 1));
        end
    endtask
    task t_wait;
        int p, n;
        bus(1'b1, 6'h08, 8'h02);
        bus(1'b1, 6'h04, 8'h02);
        wait_mode_in <= 1'b1;
        tick(10);
        moves_of(1'b1, n);
        chk(n, 32'h0);
        wait_mode_in <= 1'b0;
        sck_period(p);
        chk(p, 32'h8);
        bus(1'b1, 6'h04, 8'h00);
        wait_mode_in <= 1'b1;
        sck_period(p);
        chk(p, 32'h8);
        wait_mode_in <= 1'b0;
    endtask
    task t_fault;
        bus(1'b1, 6'h04, 8'h10);
        sel_low_in <= 1'b1;
        tick(8);
        rd_chk(6'h0C, 32'h10);
        sel_low_in <= 1'b0;
        tick(8);
        bus(1'b1, 6'h00, 8'h10);
        rd_chk(6'h0C, 32'h00);
        wr_abort(6'h04, 8'h11);
        wr_abort(6'h04, 8'h19);
        wr_abort(6'h04, 8'h09);
    endtask
    task t_slave_clock;
        int n;
        bus(1'b1, 6'h04, 8'h00);
        bus(1'b1, 6'h00, 8'h00);
        drive_in <= 1'b0;
        clock_run_in <= 1'b1;
        tick(8);
        chk(sck_pin_oe_out, 32'h0);
        moves_of(1'b0, n);
        chk(n, 32'hA);
        clock_run_in <= 1'b0;
    endtask
    initial begin
        sys_rst_in = 1'b1;
        avs_address_in = 6'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        wait_mode_in = 1'b0;
        sel_low_in = 1'b0;
        drive_in = 1'b1;
        data_in = 1'b0;
        clock_run_in = 1'b0;
        tick(16);
        sys_rst_in <= 1'b0;
        t_regs();
        t_roles();
        t_baud();
        t_wait();
        t_fault();
        t_slave_clock();
        give_verdict();
    end
endmodule // spi_pin_mode_and_baud_bench
